//--- core/sidrf_pkg.sv
// constants, types and format tables for the source tag response framer
package sidrf_pkg;
   // register addresses
   localparam logic [7:0] ADDR_TAG0   = 8'h1A;
   localparam logic [7:0] ADDR_TAG1   = 8'h1B;
   localparam logic [7:0] ADDR_TIMING = 8'h22;
   localparam logic [7:0] REG_ZERO    = 8'h00;
   // reserved bits 6:4 of the second tag register
   localparam logic [7:0] TAG1_WMASK  = 8'h8F;
   // tag register fields
   localparam int EN_BIT = 7;
   localparam int FMT_HI = 6;
   localparam int FMT_LO = 4;
   localparam int TAG_HI = 3;
   localparam int TAG_LO = 0;
   // timing register fields
   localparam int PER_HI     = 7;
   localparam int PER_LO     = 5;
   localparam int TRAIN_BIT  = 4;
   localparam int CALRST_BIT = 3;
   localparam int CRM_HI     = 2;
   localparam int CRM_LO     = 1;
   localparam int CALEN_BIT  = 0;

   typedef enum logic [2:0] {
      mode_dsi3,
      mode_psi5_async,
      mode_psi5_sync,
      mode_psi5_daisy,
      mode_psi5_prog,
      mode_spi,
      mode_i2c
   } sidrf_mode_type;

   typedef struct packed {
      logic [2:0] tag_bits;
      logic [1:0] ka_bits;
      logic [2:0] stat_bits;
      logic [4:0] data_bits;
      logic [5:0] total_bits;
   } sidrf_fmt_type;

   // periodic response layouts, indexed by format code
   localparam sidrf_fmt_type FMT_TABLE [8] = '{
      '{3'h0, 2'h2, 3'h4, 5'h0A, 6'h18},
      '{3'h4, 2'h2, 3'h4, 5'h0A, 6'h1C},
      '{3'h0, 2'h0, 3'h4, 5'h0C, 6'h18},
      '{3'h4, 2'h0, 3'h4, 5'h0C, 6'h1C},
      '{3'h0, 2'h2, 3'h0, 5'h0A, 6'h14},
      '{3'h0, 2'h0, 3'h0, 5'h10, 6'h18},
      '{3'h0, 2'h0, 3'h4, 5'h10, 6'h1C},
      '{3'h4, 2'h0, 3'h4, 5'h10, 6'h20}
   };
   localparam logic [4:0] PSI5_DATA_NARROW = 5'h0A;
   localparam logic [4:0] PSI5_DATA_WIDE   = 5'h10;
   localparam logic [2:0] TAG_FIELD_NONE   = 3'h0;

   // periodic period in microseconds, indexed by period select
   localparam logic [11:0] PERIOD_US [8] = '{
      12'h064, 12'h07D, 12'h0FA, 12'h14D,
      12'h1F4, 12'h320, 12'h3E8, 12'h7D0
   };
   localparam logic [3:0]  CRM_UNIT  = 4'h1;
   localparam logic [12:0] START_NOW = 13'h0000;
endpackage

//--- core/sidrf_top.sv
// source tag selection and response format logic for sensor frames
`timescale 1ns/100ps

// Operation
// - format codes 0-3 give periodic field sizes
// - format codes 4-7 give periodic field sizes
// - PSI5 uses format top bit only
// - PSI5 programming mode fixes 10-bit data
// - SPI/I2C format bits stored, otherwise unused
// - SPI single enabled match returns that word
// - SPI no or double match gives error
// - DSI3 enabled source sends word, tag only in formats with a tag field
// - PSI5 ignores tag values, sync and programming modes use enables
// - PSI5 async/daisy always sends source zero only
// - PSI5 sync sends enabled sources at start times
// - timing register writable outside normal PSI5
// - timing register included in config check
// - timing register field layout, default from i_otp_timing
// - tag register field layouts
// - period select decodes to microseconds when calibrating
module sidrf_top (
   // clock and reset
   input  wire logic                    i_mclk,
   input  wire logic                    i_rst_n,
   // defaults loaded after reset
   input  wire logic [7:0]              i_otp_tag0,
   input  wire logic [7:0]              i_otp_tag1,
   input  wire logic [7:0]              i_otp_timing,
   // active protocol
   input  wire sidrf_pkg::sidrf_mode_type i_comm_mode,
   // register port
   input  wire logic [7:0]              i_reg_addr,
   input  wire logic                    i_reg_wr,
   input  wire logic                    i_reg_rd,
   input  wire logic [7:0]              i_reg_wdata,
   output logic      [7:0]              o_reg_rdata,
   output logic                         o_reg_rvalid,
   // sensor words and slot start times
   input  wire logic [15:0]             i_sensor_word0,
   input  wire logic [15:0]             i_sensor_word1,
   input  wire logic [12:0]             i_rsp_start0,
   input  wire logic [12:0]             i_rsp_start1,
   // frame triggers
   input  wire logic                    i_sync_pulse,
   input  wire logic                    i_async_tick,
   // frame descriptor to the encoder
   output logic                         o_tx_valid,
   output logic                         o_tx_source,
   output logic      [3:0]              o_tx_tag,
   output logic      [15:0]             o_tx_word,
   output logic      [12:0]             o_tx_start,
   output logic      [2:0]              o_tx_tag_bits,
   output logic      [1:0]              o_tx_ka_bits,
   output logic      [2:0]              o_tx_stat_bits,
   output logic      [4:0]              o_tx_data_bits,
   output logic      [5:0]              o_tx_total_bits,
   // spi sensor data request
   input  wire logic                    i_spi_req,
   input  wire logic [3:0]              i_spi_tag,
   output logic                         o_spi_valid,
   output logic                         o_spi_err,
   output logic                         o_spi_source,
   output logic      [15:0]             o_spi_word,
   // timing configuration view
   output logic      [11:0]             o_period_us,
   output logic      [3:0]              o_crm_multiple,
   output logic                         o_cal_en,
   output logic                         o_cal_rst,
   output logic                         o_train_sel,
   output logic      [7:0]              o_cfg_check
);

   typedef enum {st_idle, st_src0, st_src1} sidrf_state_type;

   function automatic logic is_psi5_run(input sidrf_pkg::sidrf_mode_type m);
      return (m == sidrf_pkg::mode_psi5_async) ||
             (m == sidrf_pkg::mode_psi5_sync) ||
             (m == sidrf_pkg::mode_psi5_daisy);
   endfunction

   function automatic sidrf_pkg::sidrf_fmt_type fmt_decode(
      input logic [2:0] code,
      input sidrf_pkg::sidrf_mode_type m);
      sidrf_pkg::sidrf_fmt_type f;
      f = sidrf_pkg::FMT_TABLE[code];
      if (is_psi5_run(m) || m == sidrf_pkg::mode_psi5_prog) begin
         f = '0;
         f.data_bits = code[2] ? sidrf_pkg::PSI5_DATA_WIDE
                               : sidrf_pkg::PSI5_DATA_NARROW;
         if (m == sidrf_pkg::mode_psi5_prog) begin
            f.data_bits = sidrf_pkg::PSI5_DATA_NARROW;
         end
         f.total_bits = {1'b0, f.data_bits};
      end
      return f;
   endfunction

   // configuration registers
   logic       loaded, next_loaded;
   logic [7:0] tag0, next_tag0;
   logic [7:0] tag1, next_tag1;
   logic [7:0] timing, next_timing;
   logic       wr_ok;

   assign wr_ok = i_reg_wr && !is_psi5_run(i_comm_mode);

   always_comb begin
      next_loaded = 1'b1;
      next_tag0   = tag0;
      next_tag1   = tag1;
      next_timing = timing;
      if (!loaded) begin
         // defaults caught after reset release, not under it
         next_tag0   = i_otp_tag0;
         next_tag1   = i_otp_tag1 & sidrf_pkg::TAG1_WMASK;
         next_timing = i_otp_timing;
      end else if (wr_ok) begin
         if (i_reg_addr == sidrf_pkg::ADDR_TAG0) begin
            next_tag0 = i_reg_wdata;
         end
         if (i_reg_addr == sidrf_pkg::ADDR_TAG1) begin
            next_tag1 = i_reg_wdata & sidrf_pkg::TAG1_WMASK;
         end
         if (i_reg_addr == sidrf_pkg::ADDR_TIMING) begin
            next_timing = i_reg_wdata;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         loaded <= 1'b0;
         tag0   <= sidrf_pkg::REG_ZERO;
         tag1   <= sidrf_pkg::REG_ZERO;
         timing <= sidrf_pkg::REG_ZERO;
      end else begin
         loaded <= next_loaded;
         tag0   <= next_tag0;
         tag1   <= next_tag1;
         timing <= next_timing;
      end
   end

   // register reads and timing view
   logic [7:0]  next_rdata;
   logic        next_rvalid;
   logic [11:0] next_period;
   logic [7:0]  next_check;

   always_comb begin
      next_rvalid = i_reg_rd;
      next_rdata  = o_reg_rdata;
      if (i_reg_rd) begin
         unique case (i_reg_addr)
            sidrf_pkg::ADDR_TAG0:   next_rdata = tag0;
            sidrf_pkg::ADDR_TAG1:   next_rdata = tag1;
            sidrf_pkg::ADDR_TIMING: next_rdata = timing;
            default:                next_rdata = sidrf_pkg::REG_ZERO;
         endcase
      end
      next_period = '0;
      if (timing[sidrf_pkg::CALEN_BIT]) begin
         next_period =
            sidrf_pkg::PERIOD_US[timing[sidrf_pkg::PER_HI:sidrf_pkg::PER_LO]];
      end
      next_check = tag0 ^ tag1 ^ timing;
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_reg_rdata    <= sidrf_pkg::REG_ZERO;
         o_reg_rvalid   <= 1'b0;
         o_period_us    <= '0;
         o_crm_multiple <= sidrf_pkg::CRM_UNIT;
         o_cal_en       <= 1'b0;
         o_cal_rst      <= 1'b0;
         o_train_sel    <= 1'b0;
         o_cfg_check    <= sidrf_pkg::REG_ZERO;
      end else begin
         o_reg_rdata    <= next_rdata;
         o_reg_rvalid   <= next_rvalid;
         o_period_us    <= next_period;
         o_crm_multiple <= sidrf_pkg::CRM_UNIT <<
                           timing[sidrf_pkg::CRM_HI:sidrf_pkg::CRM_LO];
         o_cal_en       <= timing[sidrf_pkg::CALEN_BIT];
         o_cal_rst      <= timing[sidrf_pkg::CALRST_BIT];
         o_train_sel    <= timing[sidrf_pkg::TRAIN_BIT];
         o_cfg_check    <= next_check;
      end
   end

   // frame sequencer: snapshot then at most one descriptor per source
   sidrf_state_type           state, next_state;
   logic [7:0]                snap0, next_snap0;
   logic [7:0]                snap1, next_snap1;
   logic                      force0, next_force0;
   sidrf_pkg::sidrf_mode_type snap_mode, next_snap_mode;
   sidrf_pkg::sidrf_fmt_type  fmt, next_fmt;
   logic                      next_tx_valid;
   logic                      next_tx_source;
   logic [3:0]                next_tx_tag;
   logic [15:0]               next_tx_word;
   logic [12:0]               next_tx_start;
   logic                      sync_frame;
   logic                      async_frame;

   // programming mode frames must reach the narrow decode
   assign sync_frame  = i_sync_pulse &&
                        (i_comm_mode == sidrf_pkg::mode_dsi3 ||
                         i_comm_mode == sidrf_pkg::mode_psi5_prog ||
                         i_comm_mode == sidrf_pkg::mode_psi5_sync);
   assign async_frame = i_async_tick &&
                        (i_comm_mode == sidrf_pkg::mode_psi5_async ||
                         i_comm_mode == sidrf_pkg::mode_psi5_daisy);

   always_comb begin
      next_state     = state;
      next_snap0     = snap0;
      next_snap1     = snap1;
      next_force0    = force0;
      next_snap_mode = snap_mode;
      next_fmt       = fmt;
      next_tx_valid  = 1'b0;
      next_tx_source = o_tx_source;
      next_tx_tag    = o_tx_tag;
      next_tx_word   = o_tx_word;
      next_tx_start  = o_tx_start;
      unique case (state)
         st_idle: begin
            if (sync_frame || async_frame) begin
               next_snap0     = tag0;
               next_snap1     = tag1;
               next_force0    = async_frame;
               next_snap_mode = i_comm_mode;
               next_fmt       = fmt_decode(tag0[sidrf_pkg::FMT_HI:
                                                sidrf_pkg::FMT_LO],
                                           i_comm_mode);
               next_state     = st_src0;
            end
         end
         st_src0: begin
            if (snap0[sidrf_pkg::EN_BIT] || force0) begin
               next_tx_valid  = 1'b1;
               next_tx_source = 1'b0;
               next_tx_word   = i_sensor_word0;
               next_tx_start  = force0 ? sidrf_pkg::START_NOW
                                       : i_rsp_start0;
               next_tx_tag    = snap0[sidrf_pkg::TAG_HI:sidrf_pkg::TAG_LO];
            end
            next_state = force0 ? st_idle : st_src1;
         end
         st_src1: begin
            if (snap1[sidrf_pkg::EN_BIT]) begin
               next_tx_valid  = 1'b1;
               next_tx_source = 1'b1;
               next_tx_word   = i_sensor_word1;
               next_tx_start  = i_rsp_start1;
               next_tx_tag    = snap1[sidrf_pkg::TAG_HI:sidrf_pkg::TAG_LO];
            end
            next_state = st_idle;
         end
      endcase
      if (snap_mode != sidrf_pkg::mode_dsi3 ||
          fmt.tag_bits == sidrf_pkg::TAG_FIELD_NONE) begin
         next_tx_tag = '0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state           <= st_idle;
         snap0           <= sidrf_pkg::REG_ZERO;
         snap1           <= sidrf_pkg::REG_ZERO;
         force0          <= 1'b0;
         snap_mode       <= sidrf_pkg::mode_dsi3;
         fmt             <= '0;
         o_tx_valid      <= 1'b0;
         o_tx_source     <= 1'b0;
         o_tx_tag        <= '0;
         o_tx_word       <= '0;
         o_tx_start      <= '0;
         o_tx_tag_bits   <= '0;
         o_tx_ka_bits    <= '0;
         o_tx_stat_bits  <= '0;
         o_tx_data_bits  <= '0;
         o_tx_total_bits <= '0;
      end else begin
         state           <= next_state;
         snap0           <= next_snap0;
         snap1           <= next_snap1;
         force0          <= next_force0;
         snap_mode       <= next_snap_mode;
         fmt             <= next_fmt;
         o_tx_valid      <= next_tx_valid;
         o_tx_source     <= next_tx_source;
         o_tx_tag        <= next_tx_tag;
         o_tx_word       <= next_tx_word;
         o_tx_start      <= next_tx_start;
         o_tx_tag_bits   <= fmt.tag_bits;
         o_tx_ka_bits    <= fmt.ka_bits;
         o_tx_stat_bits  <= fmt.stat_bits;
         o_tx_data_bits  <= fmt.data_bits;
         o_tx_total_bits <= fmt.total_bits;
      end
   end

   logic        hit0, hit1;
   logic        next_spi_valid;
   logic        next_spi_err;
   logic        next_spi_source;
   logic [15:0] next_spi_word;

   assign hit0 = tag0[sidrf_pkg::EN_BIT] &&
                 tag0[sidrf_pkg::TAG_HI:sidrf_pkg::TAG_LO] == i_spi_tag;
   assign hit1 = tag1[sidrf_pkg::EN_BIT] &&
                 tag1[sidrf_pkg::TAG_HI:sidrf_pkg::TAG_LO] == i_spi_tag;

   always_comb begin
      next_spi_valid  = i_spi_req;
      next_spi_err    = o_spi_err;
      next_spi_source = o_spi_source;
      next_spi_word   = o_spi_word;
      if (i_spi_req) begin
         next_spi_err    = !(hit0 ^ hit1);
         next_spi_source = hit1 && !hit0;
         next_spi_word   = (hit0 ^ hit1) ?
                           (hit1 ? i_sensor_word1 : i_sensor_word0) : '0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_spi_valid  <= 1'b0;
         o_spi_err    <= 1'b0;
         o_spi_source <= 1'b0;
         o_spi_word   <= '0;
      end else begin
         o_spi_valid  <= next_spi_valid;
         o_spi_err    <= next_spi_err;
         o_spi_source <= next_spi_source;
         o_spi_word   <= next_spi_word;
      end
   end

endmodule

//--- tb/sidrf_checker_assertions.sv
// concurrent checks on the source tag framer ports
`timescale 1ns/100ps
module sidrf_checker (
   // clock and reset
   input wire logic                      i_mclk,
   input wire logic                      i_rst_n,
   // stimulus side
   input wire sidrf_pkg::sidrf_mode_type i_comm_mode,
   input wire logic [7:0]                i_reg_addr,
   input wire logic                      i_reg_rd,
   input wire logic                      i_sync_pulse,
   input wire logic                      i_async_tick,
   input wire logic                      i_spi_req,
   // design outputs
   input wire logic [7:0]                o_reg_rdata,
   input wire logic                      o_reg_rvalid,
   input wire logic                      o_tx_valid,
   input wire logic                      o_tx_source,
   input wire logic [3:0]                o_tx_tag,
   input wire logic [12:0]               o_tx_start,
   input wire logic [2:0]                o_tx_tag_bits,
   input wire logic [1:0]                o_tx_ka_bits,
   input wire logic [2:0]                o_tx_stat_bits,
   input wire logic [4:0]                o_tx_data_bits,
   input wire logic [5:0]                o_tx_total_bits,
   input wire logic                      o_spi_valid,
   input wire logic                      o_spi_err,
   input wire logic                      o_spi_source,
   input wire logic [15:0]               o_spi_word,
   input wire logic                      o_cal_en,
   input wire logic [11:0]               o_period_us
);
   logic psi5;
   logic async;
   assign async = i_comm_mode inside {sidrf_pkg::mode_psi5_async,
                                      sidrf_pkg::mode_psi5_daisy};
   assign psi5 = async || i_comm_mode inside {sidrf_pkg::mode_psi5_sync,
                                              sidrf_pkg::mode_psi5_prog};
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_rd_answer: assert property (
      i_reg_rd |=> o_reg_rvalid) else $error("read not answered");
   a_unmapped_zero: assert property (
      i_reg_rd && !(i_reg_addr inside {8'h1A, 8'h1B, 8'h22})
      |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_spi_answer: assert property (
      i_spi_req |=> o_spi_valid) else $error("spi request not answered");
   a_spi_err_word: assert property (
      o_spi_valid && o_spi_err |-> o_spi_word == 16'h0000 && !o_spi_source)
      else $error("spi error carries data");
   a_src0_latency: assert property (
      o_tx_valid && !o_tx_source
      |-> $past(i_sync_pulse, 2) || $past(i_async_tick, 2))
      else $error("source zero frame at wrong time");
   a_src1_latency: assert property (
      o_tx_valid && o_tx_source |-> $past(i_sync_pulse, 3))
      else $error("source one frame at wrong time");
   a_async_src_zero: assert property (
      o_tx_valid && async |-> !o_tx_source && o_tx_start == 13'h0000)
      else $error("async frame from wrong source");
   a_psi5_width: assert property (
      o_tx_valid && psi5 |-> o_tx_data_bits inside {5'h0A, 5'h10}
      && o_tx_total_bits == 6'(o_tx_data_bits))
      else $error("psi5 data width wrong");
   a_psi5_no_tag: assert property (
      o_tx_valid && psi5 |-> o_tx_tag == 4'h0 && o_tx_tag_bits == 3'h0)
      else $error("psi5 frame carries a tag");
   a_dsi3_total: assert property (
      o_tx_valid && i_comm_mode == sidrf_pkg::mode_dsi3
      |-> 7'(o_tx_tag_bits) + 7'(o_tx_ka_bits) + 7'(o_tx_stat_bits)
      + 7'(o_tx_data_bits) + 7'h08 == 7'(o_tx_total_bits))
      else $error("periodic field sizes do not add up");
   a_cal_off_period: assert property (
      !o_cal_en |-> o_period_us == 12'h000) else $error("period shown");
   c_spi_error: cover property (o_spi_valid && o_spi_err);
   c_second_src: cover property (o_tx_valid && o_tx_source);
   c_async_frame: cover property (o_tx_valid && async);
endmodule

bind sidrf_top sidrf_checker u_chk (.i_mclk, .i_rst_n, .i_comm_mode,
   .i_reg_addr, .i_reg_rd, .i_sync_pulse, .i_async_tick, .i_spi_req,
   .o_reg_rdata, .o_reg_rvalid, .o_tx_valid, .o_tx_source, .o_tx_tag,
   .o_tx_start, .o_tx_tag_bits, .o_tx_ka_bits, .o_tx_stat_bits,
   .o_tx_data_bits, .o_tx_total_bits, .o_spi_valid, .o_spi_err,
   .o_spi_source, .o_spi_word, .o_cal_en, .o_period_us);

//--- tb/sidrf_master_model.sv
// behavioural frame master: issues triggers and logs descriptors
`timescale 1ns/100ps
module sidrf_master_model (
   // clock
   input  wire logic        i_mclk,
   // descriptors from the framer
   input  wire logic        i_tx_valid,
   input  wire logic        i_tx_source,
   input  wire logic [3:0]  i_tx_tag,
   input  wire logic [15:0] i_tx_word,
   input  wire logic [12:0] i_tx_start,
   // frame triggers
   output logic             o_sync_pulse,
   output logic             o_async_tick
);
   int          cnt [2];
   logic [3:0]  tag [2];
   logic [15:0] word [2];
   logic [12:0] start [2];
   initial begin
      o_sync_pulse = 1'b0;
      o_async_tick = 1'b0;
   end
   // one frame trigger per call
   // long gap so both slots of a frame land before the next trigger
   task automatic fire(input logic async);
      cnt = '{0, 0};
      o_sync_pulse = !async;
      o_async_tick = async;
      @(posedge i_mclk);
      #1;
      o_sync_pulse = 1'b0;
      o_async_tick = 1'b0;
      repeat (5) @(posedge i_mclk);
      #1;
   endtask
   always @(posedge i_mclk) begin
      if (i_tx_valid === 1'b1) begin
         cnt[i_tx_source] = cnt[i_tx_source] + 1;
         tag[i_tx_source] = i_tx_tag;
         word[i_tx_source] = i_tx_word;
         start[i_tx_source] = i_tx_start;
      end
   end
endmodule

//--- tb/tb_sidrf_top.sv
// directed bench for the source tag response framer
`timescale 1ns/100ps
module tb_sidrf_top;
   localparam logic [5:0] TOT [8] = '{6'h18, 6'h1C, 6'h18, 6'h1C,
                                     6'h14, 6'h18, 6'h1C, 6'h20};
   localparam logic [4:0] DAT [8] = '{5'h0A, 5'h0A, 5'h0C, 5'h0C,
                                     5'h0A, 5'h10, 5'h10, 5'h10};
   // tag, keep-alive and status sizes packed 3/2/3
   localparam logic [7:0] FLD [8] = '{8'h14, 8'h94, 8'h04, 8'h84,
                                     8'h10, 8'h00, 8'h04, 8'h84};
   localparam logic [11:0] PER [8] = '{12'h064, 12'h07D, 12'h0FA,
      12'h14D, 12'h1F4, 12'h320, 12'h3E8, 12'h7D0};
   logic i_mclk, i_rst_n, i_reg_wr, i_reg_rd, i_spi_req;
   logic i_sync_pulse, i_async_tick, o_reg_rvalid, o_tx_valid;
   logic o_tx_source, o_spi_valid, o_spi_err, o_spi_source;
   logic o_cal_en, o_cal_rst, o_train_sel;
   logic [7:0] i_otp_tag0, i_otp_tag1, i_otp_timing, i_reg_addr;
   logic [7:0] i_reg_wdata, o_reg_rdata, o_cfg_check;
   logic [15:0] i_sensor_word0, i_sensor_word1, o_tx_word, o_spi_word;
   logic [12:0] i_rsp_start0, i_rsp_start1, o_tx_start;
   logic [3:0] i_spi_tag, o_tx_tag, o_crm_multiple;
   logic [2:0] o_tx_tag_bits, o_tx_stat_bits;
   logic [1:0] o_tx_ka_bits;
   logic [4:0] o_tx_data_bits;
   logic [5:0] o_tx_total_bits;
   logic [11:0] o_period_us;
   sidrf_pkg::sidrf_mode_type i_comm_mode;
   int fail_count, compares;

   sidrf_top dut (.i_mclk, .i_rst_n, .i_otp_tag0, .i_otp_tag1,
      .i_otp_timing, .i_comm_mode, .i_reg_addr, .i_reg_wr, .i_reg_rd,
      .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid, .i_sensor_word0,
      .i_sensor_word1, .i_rsp_start0, .i_rsp_start1, .i_sync_pulse,
      .i_async_tick, .o_tx_valid, .o_tx_source, .o_tx_tag, .o_tx_word,
      .o_tx_start, .o_tx_tag_bits, .o_tx_ka_bits, .o_tx_stat_bits,
      .o_tx_data_bits, .o_tx_total_bits, .i_spi_req, .i_spi_tag,
      .o_spi_valid, .o_spi_err, .o_spi_source, .o_spi_word, .o_period_us,
      .o_crm_multiple, .o_cal_en, .o_cal_rst, .o_train_sel, .o_cfg_check);
   sidrf_master_model pm (.i_mclk, .i_tx_valid(o_tx_valid),
      .i_tx_source(o_tx_source), .i_tx_tag(o_tx_tag),
      .i_tx_word(o_tx_word), .i_tx_start(o_tx_start),
      .o_sync_pulse(i_sync_pulse), .o_async_tick(i_async_tick));

   initial begin
      i_mclk = 1'b0;
      forever #2 i_mclk = ~i_mclk;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_reg_addr = a;
      i_reg_wdata = d;
      i_reg_wr = 1'b1;
      tick(1);
      i_reg_wr = 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      i_reg_addr = a;
      i_reg_rd = 1'b1;
      tick(1);
      i_reg_rd = 1'b0;
      cmp(o_reg_rvalid, 1'b1);
      cmp(o_reg_rdata, exp);
      tick(1);
   endtask
   task automatic spi(input logic [3:0] t, input logic e, input logic s);
      i_spi_tag = t;
      i_spi_req = 1'b1;
      tick(1);
      i_spi_req = 1'b0;
      cmp({o_spi_valid, o_spi_err, o_spi_source}, {1'b1, e, s});
      cmp(o_spi_word, e ? 16'h0000 : (s ? i_sensor_word1 : i_sensor_word0));
      tick(1);
   endtask
   task automatic t_regs;
      rd(sidrf_pkg::ADDR_TAG0, 8'h95);
      rd(sidrf_pkg::ADDR_TAG1, 8'h86);
      rd(sidrf_pkg::ADDR_TIMING, 8'h00);
      rd(8'h30, 8'h00);
      cmp({o_cfg_check, o_crm_multiple}, 12'h131);
      for (int i = 0; i < 8; i++) begin
         wr(sidrf_pkg::ADDR_TIMING, {3'(i), 5'h1F});
         cmp(o_period_us, PER[i]);
         cmp({o_crm_multiple, o_train_sel, o_cal_rst}, 6'h23);
      end
      wr(sidrf_pkg::ADDR_TIMING, 8'hE0);
      cmp({o_period_us, o_cal_en}, 13'h0000);
      cmp(o_cfg_check, 8'hF3);
      i_comm_mode = sidrf_pkg::mode_psi5_prog;
      wr(sidrf_pkg::ADDR_TIMING, 8'h5A);
      rd(sidrf_pkg::ADDR_TIMING, 8'h5A);
      wr(sidrf_pkg::ADDR_TAG1, 8'hFF);
      rd(sidrf_pkg::ADDR_TAG1, 8'h8F);
      $display("t_regs done");
   endtask
   task automatic t_dsi3;
      i_comm_mode = sidrf_pkg::mode_dsi3;
      for (int i = 0; i < 8; i++) begin
         i_sensor_word0 = 16'h1100 + 16'(i);
         i_sensor_word1 = 16'h2200 + 16'(i);
         i_rsp_start0 = 13'h0040 + 13'(i);
         i_rsp_start1 = 13'h0800 + 13'(i);
         wr(sidrf_pkg::ADDR_TAG0, {1'b1, 3'(i), 4'h5});
         wr(sidrf_pkg::ADDR_TAG1, {i[0], 3'h0, 4'h6});
         pm.fire(1'b0);
         cmp({o_tx_total_bits, o_tx_data_bits}, {TOT[i], DAT[i]});
         cmp({o_tx_tag_bits, o_tx_ka_bits, o_tx_stat_bits}, FLD[i]);
         cmp(16'(pm.cnt[0] * 2 + pm.cnt[1]), 16'(2 + i % 2));
         cmp(pm.tag[0], FLD[i][7] ? 4'h5 : 4'h0);
         cmp(pm.word[0] ^ 16'(pm.start[0]), 16'h1140);
         if (i % 2 == 1) begin
            cmp(pm.tag[1], FLD[i][7] ? 4'h6 : 4'h0);
            cmp(pm.word[1] ^ 16'(pm.start[1]), 16'h2A00);
         end
      end
      $display("t_dsi3 done");
   endtask
   task automatic t_psi5;
      wr(sidrf_pkg::ADDR_TAG0, 8'hB5);
      wr(sidrf_pkg::ADDR_TAG1, 8'h06);
      i_comm_mode = sidrf_pkg::mode_psi5_sync;
      wr(sidrf_pkg::ADDR_TIMING, 8'hFF);
      rd(sidrf_pkg::ADDR_TIMING, 8'h5A);
      pm.fire(1'b0);
      cmp({o_tx_total_bits, o_tx_data_bits}, {6'h0A, 5'h0A});
      cmp({12'(pm.cnt[1]), pm.tag[0]}, 16'h0000);
      cmp(pm.start[0], i_rsp_start0);
      i_comm_mode = sidrf_pkg::mode_dsi3;
      wr(sidrf_pkg::ADDR_TAG0, 8'h45);
      wr(sidrf_pkg::ADDR_TAG1, 8'h86);
      i_comm_mode = sidrf_pkg::mode_psi5_sync;
      pm.fire(1'b0);
      cmp(o_tx_data_bits, 5'h10);
      cmp(16'(pm.cnt[0] * 2 + pm.cnt[1]), 16'h0001);
      cmp(pm.tag[1], 4'h0);
      cmp(pm.start[1], i_rsp_start1);
      for (int i = 0; i < 2; i++) begin
         i_comm_mode = i ? sidrf_pkg::mode_psi5_daisy
                         : sidrf_pkg::mode_psi5_async;
         pm.fire(1'b1);
         cmp(16'(pm.cnt[0] * 2 + pm.cnt[1]), 16'h0002);
         cmp(pm.word[0] ^ 16'(pm.start[0]), i_sensor_word0);
      end
      i_comm_mode = sidrf_pkg::mode_psi5_prog;
      pm.fire(1'b0);
      cmp(o_tx_data_bits, 5'h0A);
      $display("t_psi5 done");
   endtask
   task automatic t_spi;
      i_comm_mode = sidrf_pkg::mode_spi;
      wr(sidrf_pkg::ADDR_TAG0, 8'hF3);
      rd(sidrf_pkg::ADDR_TAG0, 8'hF3);
      wr(sidrf_pkg::ADDR_TAG1, 8'h89);
      pm.fire(1'b0);
      cmp(16'(pm.cnt[0] + pm.cnt[1]), 16'h0000);
      spi(4'h3, 1'b0, 1'b0);
      spi(4'h9, 1'b0, 1'b1);
      spi(4'h4, 1'b1, 1'b0);
      wr(sidrf_pkg::ADDR_TAG1, 8'h83);
      spi(4'h3, 1'b1, 1'b0);
      i_comm_mode = sidrf_pkg::mode_i2c;
      wr(sidrf_pkg::ADDR_TAG1, 8'h03);
      spi(4'h3, 1'b0, 1'b0);
      wr(sidrf_pkg::ADDR_TAG0, 8'h13);
      spi(4'h3, 1'b1, 1'b0);
      $display("t_spi done");
   endtask
   task automatic finish_test;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge i_mclk);
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
   initial begin
      {i_rst_n, i_reg_wr, i_reg_rd, i_spi_req, i_spi_tag} = 8'h00;
      {i_reg_addr, i_reg_wdata} = 16'h0000;
      {i_otp_tag0, i_otp_tag1, i_otp_timing} = 24'h95F600;
      {i_sensor_word0, i_sensor_word1} = 32'h1140_2A00;
      {i_rsp_start0, i_rsp_start1} = 26'h0;
      i_comm_mode = sidrf_pkg::mode_dsi3;
      repeat (16) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      tick(2);
      t_regs();
      t_dsi3();
      t_psi5();
      t_spi();
      finish_test();
   end
endmodule
